// ===== src/clk_pkg.sv
package clk_pkg;
  // Source select codes as stored in the fuses.
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC8M = 4'h2;
  localparam logic [3:0] SRC_RC128K = 4'h4;
  localparam logic [3:0] SRC_LFXO = 4'h6;
  localparam int SRC_XO_BIT = 3;
  // Start-up time fuse codes.
  localparam logic [1:0] DLY_SHORT = 2'h0;
  localparam logic [1:0] DLY_4MS = 2'h1;
  localparam logic [1:0] DLY_64MS = 2'h2;
  localparam logic [1:0] DLY_RSVD = 2'h3;
  // A stored zero means the fuse is programmed.
  localparam logic FUSE_PROG = 1'b0;
  localparam logic FUSE_UNPROG = 1'b1;
  // Cycle counts on the selected source.
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] PD_CK = 14'h0006;
  localparam logic [CNT_W-1:0] RST_CK = 14'h000e;
  localparam int XO_PD_CK = 1024;
  // Reset time-outs, counted on the 128 kHz watchdog oscillator.
  localparam int WDT_OSC_KHZ = 128;
  localparam int T_4MS_MS = 4;
  localparam int T_64MS_MS = 64;
  localparam int WDT_4MS_CYC = T_4MS_MS * WDT_OSC_KHZ;
  localparam int WDT_64MS_CYC = T_64MS_MS * WDT_OSC_KHZ;
  // Synchroniser channels.
  localparam int CH_CK = 0;
  localparam int CH_WDT = 1;
  localparam int CH_IRQ = 2;
  // Register map and fields.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CAL = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int STAT_FAULT_BIT = 4;
  localparam int STAT_RUN_BIT = 5;
  localparam int STAT_IRQ_BIT = 6;
  typedef enum logic [1:0] {SM_IDLE, SM_ADC_NR, SM_PWR_DOWN} sleep_mode_t;
  typedef enum logic [2:0] {
    ST_LATCH, ST_RST_CK, ST_RST_WDT, ST_RUN, ST_SLEEP, ST_WAKE_CK, ST_FAULT
  } state_t;
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] dly;
    logic rst_dis;
    logic div8;
  } fuse_t;
  typedef struct packed {
    logic core;
    logic io;
    logic flash;
    logic adc;
  } clk_en_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  // Fuse image of a device as delivered.
  localparam fuse_t SHIP_FUSE = '{src: SRC_RC8M, dly: DLY_64MS, rst_dis: FUSE_UNPROG,
                                  div8: FUSE_PROG};
endpackage : clk_pkg

// ===== src/clock_startup.sv
`timescale 1ns/1ns
// Function
// - Decode source fuses: 0000 ext, 0010 RC, 0100 128k, 0110 LF, 1xxx crystal.
// - A fuse bit stored as zero is programmed, one is unprogrammed.
// - Wake from power-down waits its cycle count on the selected clock.
// - Reset adds a watchdog delay: 512 cycles for 4 ms, 8192 for 64 ms.
// - External clock: 6 cycles from power-down; reset 14, plus 4 or 64 ms.
// - Reset loads the factory calibration byte into the trim register.
// - Software may rewrite the trim register, retrimming the RC oscillator.
// - Internal 8 MHz RC uses the same start-up options as external clock.
// - Reset pin disabled turns the 14-cycle option into 14 cycles plus 4 ms.
// - Watchdog and reset time-out always run on the watchdog oscillator.
// - Some external interrupts are seen even with peripheral clock halted.
// - Program memory clock runs and halts together with the core clock.
// - In ADC noise reduction mode the converter clock keeps running while core and peripherals are halted.
// - Sleep mode halts unused clocks; halting core stops all core work.
// - Delivered fuses: internal RC, start-up code 10, divide by eight.
// - 128 kHz source: 6 cycles from power-down, same reset options.
module clock_startup #(
  parameter int WDT_LONG_CYC = clk_pkg::WDT_64MS_CYC,
  parameter int WDT_SHORT_CYC = clk_pkg::WDT_4MS_CYC,
  parameter int XO_PD_CYC = clk_pkg::XO_PD_CK
) (
  input wire logic CLK_IN, // System clock, 250 MHz.
  input wire logic RESET_IN, // Asynchronous reset, active high.
  input wire clk_pkg::apb_req_t APB_REQ_IN, // Register bus request.
  output clk_pkg::apb_rsp_t APB_RSP_OUT, // Register bus answer.
  input wire clk_pkg::fuse_t FUSE_IN, // Stored fuse bits.
  input wire logic FUSE_BLANK_IN, // High selects the delivered fuse image.
  input wire logic [7:0] FACTORY_CAL_IN, // Factory calibration byte.
  input wire logic SEL_OSC_IN, // Selected source clock, asynchronous.
  input wire logic WDT_OSC_IN, // Watchdog oscillator, asynchronous.
  input wire logic EXT_IRQ_IN, // External interrupt pin, asynchronous.
  input wire logic WAKE_IN, // Other wake request, same clock.
  output clk_pkg::clk_en_t CLK_EN_OUT, // Clock domain enables.
  output logic [3:0] OSC_SRC_OUT, // Source select to the oscillator mux.
  output logic [7:0] OSC_TRIM_OUT, // RC oscillator trim.
  output logic PRESCALE8_OUT, // Start with divide by eight.
  output logic WDT_TICK_OUT, // One pulse per watchdog oscillator cycle.
  output logic IRQ_DETECT_OUT, // Sticky external interrupt.
  output logic SRC_FAULT_OUT // Reserved fuse code latched.
);
  typedef struct packed {
    clk_pkg::state_t st;
    clk_pkg::sleep_mode_t mode;
    clk_pkg::fuse_t fuse;
    logic [7:0] cal;
    logic [clk_pkg::CNT_W-1:0] cnt;
    logic [2:0][2:0] sync;
    logic [2:0] filt;
    logic irq_pend;
    logic wdt_tick;
    clk_pkg::clk_en_t en;
    logic [31:0] prdata;
  } regs_t;

  localparam regs_t RST_VAL = '{st: clk_pkg::ST_LATCH, mode: clk_pkg::SM_IDLE,
                                fuse: clk_pkg::SHIP_FUSE, default: '0};

  regs_t r;
  regs_t n;
  logic [2:0] raw;
  logic [2:0] rise;
  logic xo;
  logic [clk_pkg::CNT_W-1:0] pd_tgt;
  logic [clk_pkg::CNT_W-1:0] wdt_tgt;
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd;
  clk_pkg::fuse_t eff;

  // Crystal-type sources take the longer power-down count.
  function automatic logic is_xo(input logic [3:0] src);
    is_xo = src[clk_pkg::SRC_XO_BIT] | (src == clk_pkg::SRC_LFXO);
  endfunction : is_xo

  assign raw = {EXT_IRQ_IN, WDT_OSC_IN, SEL_OSC_IN};
  assign acc = APB_REQ_IN.psel & APB_REQ_IN.penable;
  assign wr = acc & APB_REQ_IN.pwrite;
  assign hit = (APB_REQ_IN.paddr == clk_pkg::ADDR_CTRL) |
               (APB_REQ_IN.paddr == clk_pkg::ADDR_CAL) |
               (APB_REQ_IN.paddr == clk_pkg::ADDR_STAT);
  assign eff = FUSE_BLANK_IN ? clk_pkg::SHIP_FUSE : FUSE_IN;

  // Targets follow the latched fuses, so they hold still during a count.
  always_comb begin
    xo = is_xo(r.fuse.src);
    pd_tgt = xo ? clk_pkg::CNT_W'(XO_PD_CYC) : clk_pkg::PD_CK;
    unique case (r.fuse.dly)
      clk_pkg::DLY_SHORT: begin
        wdt_tgt = (r.fuse.rst_dis == clk_pkg::FUSE_PROG) ?
                  clk_pkg::CNT_W'(WDT_SHORT_CYC) : '0;
      end
      clk_pkg::DLY_4MS: wdt_tgt = clk_pkg::CNT_W'(WDT_SHORT_CYC);
      default: wdt_tgt = clk_pkg::CNT_W'(WDT_LONG_CYC);
    endcase
  end

  // Read mux; reserved bits read as zero.
  always_comb begin
    rd = '0;
    if (APB_REQ_IN.paddr == clk_pkg::ADDR_CTRL) begin
      rd[1:0] = r.mode;
    end else if (APB_REQ_IN.paddr == clk_pkg::ADDR_CAL) begin
      rd[7:0] = r.cal;
    end else if (APB_REQ_IN.paddr == clk_pkg::ADDR_STAT) begin
      rd[3:0] = r.fuse.src;
      rd[clk_pkg::STAT_FAULT_BIT] = (r.st == clk_pkg::ST_FAULT);
      rd[clk_pkg::STAT_RUN_BIT] = (r.st == clk_pkg::ST_RUN);
      rd[clk_pkg::STAT_IRQ_BIT] = r.irq_pend;
    end
  end

  // Next state of the whole block.
  always_comb begin
    n = r;
    rise = '0;
    // Three-stage sampling; a level counts once stages two and three agree.
    for (int i = 0; i < 3; i++) begin
      n.sync[i] = {r.sync[i][1:0], raw[i]};
      if (r.sync[i][1] == r.sync[i][2]) begin
        n.filt[i] = r.sync[i][2];
        rise[i] = r.sync[i][2] & ~r.filt[i];
      end
    end
    n.wdt_tick = rise[clk_pkg::CH_WDT];
    // Read data is caught in the setup phase so it stands through access.
    if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
      n.prdata = rd;
    end
    if (wr && APB_REQ_IN.paddr == clk_pkg::ADDR_CAL) begin
      n.cal = APB_REQ_IN.pwdata[7:0];
    end
    if (wr && APB_REQ_IN.paddr == clk_pkg::ADDR_CTRL) begin
      n.mode = clk_pkg::sleep_mode_t'(APB_REQ_IN.pwdata[1:0]);
    end
    if (wr && APB_REQ_IN.paddr == clk_pkg::ADDR_STAT &&
        APB_REQ_IN.pwdata[clk_pkg::STAT_IRQ_BIT]) begin
      n.irq_pend = 1'b0;
    end
    // The sampler never stops with the peripheral clock, and a set beats a clear.
    if (rise[clk_pkg::CH_IRQ]) begin
      n.irq_pend = 1'b1;
    end
    unique case (r.st)
      clk_pkg::ST_LATCH: begin
        // Fuses and calibration are caught at the first edge after reset.
        n.fuse = eff;
        n.cal = FACTORY_CAL_IN;
        n.cnt = '0;
        if ((!eff.src[clk_pkg::SRC_XO_BIT] && eff.src[0]) ||
            (!is_xo(eff.src) && eff.dly == clk_pkg::DLY_RSVD)) begin
          n.st = clk_pkg::ST_FAULT;
        end else begin
          n.st = clk_pkg::ST_RST_CK;
        end
      end
      clk_pkg::ST_RST_CK: begin
        if (rise[clk_pkg::CH_CK]) begin
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == clk_pkg::RST_CK - 1'b1) begin
            n.cnt = '0;
            n.st = clk_pkg::ST_RST_WDT;
          end
        end
      end
      clk_pkg::ST_RST_WDT: begin
        if (r.cnt >= wdt_tgt) begin
          n.cnt = '0;
          n.st = clk_pkg::ST_RUN;
        end else if (rise[clk_pkg::CH_WDT]) begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      clk_pkg::ST_RUN: begin
        if (wr && APB_REQ_IN.paddr == clk_pkg::ADDR_CTRL &&
            APB_REQ_IN.pwdata[clk_pkg::CTRL_SLEEP_BIT]) begin
          n.st = clk_pkg::ST_SLEEP;
        end
      end
      clk_pkg::ST_SLEEP: begin
        // Idle and noise reduction keep the source running; every other mode, power-down included, takes a start-up count.
        if (rise[clk_pkg::CH_IRQ] || WAKE_IN) begin
          n.cnt = '0;
          if (r.mode == clk_pkg::SM_IDLE || r.mode == clk_pkg::SM_ADC_NR) begin
            n.st = clk_pkg::ST_RUN;
          end else begin
            n.st = clk_pkg::ST_WAKE_CK;
          end
        end
      end
      clk_pkg::ST_WAKE_CK: begin
        if (rise[clk_pkg::CH_CK]) begin
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == pd_tgt - 1'b1) begin
            n.cnt = '0;
            n.st = clk_pkg::ST_RUN;
          end
        end
      end
      clk_pkg::ST_FAULT: begin
        // A reserved fuse code keeps every clock halted until the next reset.
        n.st = clk_pkg::ST_FAULT;
      end
      default: n.st = clk_pkg::ST_FAULT;
    endcase
    n.en = '0;
    if (n.st == clk_pkg::ST_RUN) begin
      n.en = '1;
    end else if (n.st == clk_pkg::ST_SLEEP) begin
      // converter keeps running in idle and noise reduction only
      // The new mode is used, so the first sleep cycle already halts the right domains.
      n.en.adc = (n.mode == clk_pkg::SM_IDLE) || (n.mode == clk_pkg::SM_ADC_NR);
      n.en.io = (n.mode == clk_pkg::SM_IDLE);
    end
    n.en.flash = n.en.core;
  end

  // One register stage for the whole block.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error.
  assign APB_RSP_OUT.prdata = r.prdata;
  assign APB_RSP_OUT.pready = 1'b1;
  assign APB_RSP_OUT.pslverr = acc & ~hit;
  assign CLK_EN_OUT = r.en;
  assign OSC_SRC_OUT = r.fuse.src;
  assign OSC_TRIM_OUT = r.cal;
  assign PRESCALE8_OUT = (r.fuse.div8 == clk_pkg::FUSE_PROG);
  assign WDT_TICK_OUT = r.wdt_tick;
  assign IRQ_DETECT_OUT = r.irq_pend;
  assign SRC_FAULT_OUT = (r.st == clk_pkg::ST_FAULT);

  // Checks on the sequencer and the clock enables.
  a_reserved_src: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_LATCH && !eff.src[clk_pkg::SRC_XO_BIT] && eff.src[0])
    |=> SRC_FAULT_OUT && !CLK_EN_OUT.core)
    else $error("Reserved source code did not fault.");
  a_fuse_polarity: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_LATCH) |=> PRESCALE8_OUT == !$past(eff.div8))
    else $error("Divide fuse polarity wrong.");
  a_wake_count: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_WAKE_CK && n.st == clk_pkg::ST_RUN)
    |-> rise[clk_pkg::CH_CK] && r.cnt == pd_tgt - 1'b1)
    else $error("Wake released before its count.");
  a_wdt_timeout: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_RST_WDT && n.st == clk_pkg::ST_RUN) |-> r.cnt == wdt_tgt)
    else $error("Watchdog delay length wrong.");
  a_reset_ck_count: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_RST_CK && n.st == clk_pkg::ST_RST_WDT)
    |-> rise[clk_pkg::CH_CK] && r.cnt == clk_pkg::RST_CK - 1'b1)
    else $error("Reset cycle count wrong.");
  a_cal_load: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_LATCH) |=> OSC_TRIM_OUT == $past(FACTORY_CAL_IN))
    else $error("Factory calibration not loaded.");
  a_cal_write: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (wr && APB_REQ_IN.paddr == clk_pkg::ADDR_CAL && r.st != clk_pkg::ST_LATCH)
    |=> OSC_TRIM_OUT == $past(APB_REQ_IN.pwdata[7:0]))
    else $error("Trim write lost.");
  a_rstdis_delay: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_RST_WDT && r.fuse.dly == clk_pkg::DLY_SHORT &&
     r.fuse.rst_dis == clk_pkg::FUSE_PROG) |-> wdt_tgt == WDT_SHORT_CYC)
    else $error("Reset pin option lacks 4 ms.");
  a_wdt_tick: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    rise[clk_pkg::CH_WDT] |=> WDT_TICK_OUT ##1 !WDT_TICK_OUT)
    else $error("Watchdog tick missing.");
  a_irq_halted: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (rise[clk_pkg::CH_IRQ] && !CLK_EN_OUT.io) |=> IRQ_DETECT_OUT)
    else $error("Interrupt lost while halted.");
  a_flash_core: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    CLK_EN_OUT.flash == CLK_EN_OUT.core)
    else $error("Flash clock split from core.");
  a_adc_noise: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_SLEEP && r.mode == clk_pkg::SM_ADC_NR)
    |=> $past(n.st) != clk_pkg::ST_SLEEP || (CLK_EN_OUT.adc && !CLK_EN_OUT.io))
    else $error("Converter clock wrong in noise mode.");
  a_core_run: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    CLK_EN_OUT.core |-> r.st == clk_pkg::ST_RUN)
    else $error("Core clock on outside run.");
  a_ship_image: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_LATCH && FUSE_BLANK_IN) |=> r.fuse == clk_pkg::SHIP_FUSE)
    else $error("Delivered fuse image wrong.");
  a_release_order: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.st == clk_pkg::ST_RST_CK) |=> !CLK_EN_OUT.core &&
    (r.st == clk_pkg::ST_RST_CK || r.st == clk_pkg::ST_RST_WDT))
    else $error("Clocks released before the cycle count.");
endmodule : clock_startup

// ===== dv/osc_model.sv
`timescale 1ns/1ns
// Free-running oscillators seen by the start-up block, unrelated in phase to the system clock.
module osc_model #(
  parameter int SEL_HALF = 13,
  parameter int WDT_HALF = 41
) (
  output logic sel_osc_out, // Selected source clock.
  output logic wdt_osc_out // Watchdog oscillator.
);
  // steady source frequency
  // The period never changes, so the cycle-to-cycle limit holds even outside reset.
  initial begin
    sel_osc_out = 1'b0;
    #3;
    forever #SEL_HALF sel_osc_out = ~sel_osc_out;
  end
  initial begin
    wdt_osc_out = 1'b0;
    #7;
    forever #WDT_HALF wdt_osc_out = ~wdt_osc_out;
  end
endmodule : osc_model

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int SP = 26;
  localparam int WP = 82;
  logic clk, rst, blank, wake, irq, sel_osc, wdt_osc, prescale, tick, irq_det, fault, err;
  logic [3:0] src;
  logic [7:0] trim, cal;
  logic [31:0] rd;
  clk_pkg::apb_req_t req;
  clk_pkg::apb_rsp_t rsp;
  clk_pkg::fuse_t fuse;
  clk_pkg::clk_en_t en;
  int n_fail, tests_run, cyc, ticks, t1;
  time el;
  logic [1:0] dly_c [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  logic rdis_c [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int wdt_c [4] = '{0, 8, 8, 20};
  logic [3:0] src_c [5] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'hF};

  osc_model #(.SEL_HALF(SP / 2), .WDT_HALF(WP / 2)) u_osc_model (
    .sel_osc_out(sel_osc), .wdt_osc_out(wdt_osc));
  // Short watchdog counts keep each boot to a few hundred cycles.
  clock_startup #(.WDT_LONG_CYC(20), .WDT_SHORT_CYC(8), .XO_PD_CYC(10)) u_clock_startup (
    .CLK_IN(clk), .RESET_IN(rst), .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .FUSE_IN(fuse),
    .FUSE_BLANK_IN(blank), .FACTORY_CAL_IN(cal), .SEL_OSC_IN(sel_osc), .WDT_OSC_IN(wdt_osc),
    .EXT_IRQ_IN(irq), .WAKE_IN(wake), .CLK_EN_OUT(en), .OSC_SRC_OUT(src), .OSC_TRIM_OUT(trim),
    .PRESCALE8_OUT(prescale), .WDT_TICK_OUT(tick), .IRQ_DETECT_OUT(irq_det),
    .SRC_FAULT_OUT(fault));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle ceiling and tick counter; a hang counts as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  task results;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  // Time from now until all domains run, or a fault, bounded.
  task wait_run(input int lim);
    time t0;
    t0 = $time;
    while (en !== 4'hF && fault !== 1'b1 && $time - t0 < lim) @(negedge clk);
    el = $time - t0;
  endtask : wait_run

  // Reset with a fuse image; n is the watchdog count expected, below zero a fault.
  task boot(input logic [3:0] s, input logic [1:0] u, input logic r, input logic b, input int n);
    int lo, hi;
    lo = 13 * SP + (n > 0 ? (n - 1) * WP : 0);
    hi = 14 * SP + (n + 1) * WP + 48;
    @(posedge clk);
    fuse <= '{src: s, dly: u, rst_dis: r, div8: 1'b1};
    blank <= b;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_run(hi + 400);
    if (n < 0) begin
      chk("fault", 1, fault);
      chk("enables", 0, en);
    end else begin
      chk("startup time", 1, el >= lo && el <= hi);
    end
  endtask : boot

  // Sleep in mode m, check the enables, wake and check the wake time (k edges, 0 = at once).
  task sleep_wake(input logic [1:0] m, input logic [3:0] e, input int k, input logic by_irq);
    apb(1'b1, clk_pkg::ADDR_CTRL, {29'h0, 1'b1, m});
    repeat (3) @(negedge clk);
    chk("sleep enables", e, en);
    @(posedge clk);
    if (by_irq) irq <= 1'b1;
    else wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_run(k * SP + 400);
    chk("wake time", 1, k == 0 ? el <= 16 : el >= (k - 1) * SP && el <= k * SP + 48);
    chk("running enables", 4'hF, en);
  endtask : sleep_wake

  initial begin
    rst = 1'b1;
    fuse = '1;
    blank = 1'b0;
    wake = 1'b0;
    irq = 1'b0;
    req = '0;
    cal = 8'hA5;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    ticks = 0;
    // Delivered image, trim load and register access.
    boot(4'h0, 2'h0, 1'b1, 1'b1, 20);
    chk("source", 4'h2, src);
    chk("prescale", 1, prescale);
    chk("trim", 8'hA5, trim);
    apb(1'b0, clk_pkg::ADDR_STAT, 32'h0000_0000);
    chk("status", 32'h0000_0022, rd);
    apb(1'b1, clk_pkg::ADDR_CAL, 32'h0000_003C);
    chk("trim", 8'h3C, trim);
    apb(1'b0, clk_pkg::ADDR_CAL, 32'h0000_0000);
    chk("cal read", 32'h0000_003C, rd);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped error", 1, err);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped data", 0, rd);
    $display("test registers done");
    // Start-up options on the internal RC source.
    // The calibration byte changes on a rising edge, like the fuse, reset, wake, interrupt and bus inputs.
    @(posedge clk);
    cal <= 8'h5A;
    for (int i = 0; i < 4; i++) begin
      boot(4'h2, dly_c[i], rdis_c[i], 1'b0, wdt_c[i]);
      chk("trim", 8'h5A, trim);
      chk("prescale", 0, prescale);
    end
    boot(4'h2, 2'h3, 1'b1, 1'b0, -1);
    $display("test startup options done");
    // Source codes 0000, 0100, 0110, 1000 and 1111, then every reserved one.
    foreach (src_c[i]) begin
      boot(src_c[i], 2'h1, 1'b1, 1'b0, 8);
      chk("source", src_c[i], src);
    end
    for (int i = 0; i < 4; i++) boot(4'(2 * i + 1), 2'h1, 1'b1, 1'b0, -1);
    $display("test source codes done");
    // Sleep modes on the 128 kHz source; power-down wakes after 6 source edges.
    boot(4'h4, 2'h0, 1'b1, 1'b0, 0);
    sleep_wake(2'h0, 4'h5, 0, 1'b0);
    sleep_wake(2'h1, 4'h1, 0, 1'b0);
    sleep_wake(2'h2, 4'h0, 6, 1'b0);
    sleep_wake(2'h3, 4'h0, 6, 1'b1);
    chk("irq flag", 1, irq_det);
    apb(1'b0, clk_pkg::ADDR_STAT, 32'h0000_0000);
    chk("irq pending", 1, rd[clk_pkg::STAT_IRQ_BIT]);
    @(posedge clk);
    irq <= 1'b0;
    apb(1'b1, clk_pkg::ADDR_STAT, 32'h0000_0040);
    chk("irq cleared", 0, irq_det);
    // Crystal power-down wake counts the longer source delay.
    boot(4'h8, 2'h0, 1'b1, 1'b0, 0);
    sleep_wake(2'h2, 4'h0, 10, 1'b0);
    $display("test sleep modes done");
    // Watchdog ticks follow the watchdog oscillator, not the selected source.
    t1 = ticks;
    repeat (1000) @(posedge clk);
    chk("watchdog ticks", 1, ticks - t1 >= 48 && ticks - t1 <= 50);
    $display("test watchdog ticks done");
    results();
  end
endmodule : testbench
